//--- src/synth_load_defines.svh
// field positions, widths and reset values of the synthesizer serial load port
// assumes: included by bare name from the package, the load port module and the checker
`ifndef SYNTH_LOAD_DEFINES_SVH
`define SYNTH_LOAD_DEFINES_SVH

// ===========================================================
// shift register and select code
`define SHIFT_W 24
`define SEL_MSB 2
`define SEL_LSB 0

// ===========================================================
// latch widths
`define RF_FB_W 24
`define RF_REF_W 21
`define RF_CTRL_W 16
`define GLOBAL_W 11
`define IF_FB_W 24
`define IF_REF_W 19
`define IF_CTRL_W 16

// ===========================================================
// rf feedback divider fields
`define RF_INT_MSB 22
`define RF_INT_LSB 15
`define RF_FRAC_MSB 14
`define RF_FRAC_LSB 3

// ===========================================================
// rf reference divider fields
`define MOD_MSB 14
`define MOD_LSB 3
`define RF_R_MSB 18
`define RF_R_LSB 15
`define PRESC_BIT 20
`define DOUBLER_BIT 19

// ===========================================================
// global control fields
`define MON_MSB 10
`define MON_LSB 7

// ===========================================================
// reset values
`define LATCH_RST 24'h000000
`define SHIFT_RST 24'h000000

`endif

//--- src/synth_load_pkg.sv
// types shared by the serial load port
// assumes: synth_load_defines.svh on the include path
`default_nettype none
`include "synth_load_defines.svh"

package synth_load_pkg;

    // ===========================================================
    // latch select codes
    typedef enum logic [2:0] {
        sel_rf_feedback = 3'h0,
        sel_rf_reference = 3'h1,
        sel_rf_control = 3'h2,
        sel_global = 3'h3,
        sel_if_feedback = 3'h4,
        sel_if_reference = 3'h5,
        sel_if_control = 3'h6,
        sel_none = 3'h7
    } latch_sel_t;

    // ===========================================================
    // monitor select codes
    typedef enum logic [3:0] {
        mon_off = 4'h0,
        mon_digital_lock = 4'h1,
        mon_analog_lock = 4'h2,
        mon_high = 4'h3,
        mon_low = 4'h4
    } mon_sel_t;

    // ===========================================================
    // state of the load port apart from the pin synchronisers
    typedef struct packed {
        logic [`SHIFT_W-1:0] shift;
        logic sclk_prev;
        logic strobe_prev;
        logic [`RF_FB_W-1:0] rf_fb;
        logic [`RF_REF_W-1:0] rf_ref;
        logic [`RF_CTRL_W-1:0] rf_ctrl;
        logic [`GLOBAL_W-1:0] glob;
        logic [`IF_FB_W-1:0] if_fb;
        logic [`IF_REF_W-1:0] if_ref;
        logic [`IF_CTRL_W-1:0] if_ctrl;
        logic mon_out;
        logic mon_oe;
    } load_state_t;

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } sync_state_t;

endpackage : synth_load_pkg

`default_nettype wire

//--- src/pin_sync.sv
// two-flop synchroniser for the three serial load pins
// assumes: pins are asynchronous to clk_sys; only stage2 is read outside
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins in, synchronised levels out
    input wire logic [2:0] pins,
    output logic [2:0] pins_sync
);

    synth_load_pkg::sync_state_t s_q;
    synth_load_pkg::sync_state_t s_d;

    // ===========================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.stage1 = pins;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins_sync = s_q.stage2;

endmodule : pin_sync

`default_nettype wire

//--- src/synth_serial_register_load.sv
// serial load port of a dual synthesizer: shift register, seven latches, monitor mux
// assumes: serial pins asynchronous to clk_sys (sampled, edges found here);
// lock inputs come from logic on clk_sys
//
// Behaviour
// R01: each data bit is shifted in on a rising edge of the serial clock.
// R02: words arrive msb first; the last bit sent lands in bit zero.
// R03: latch strobe rising edge copies the shift register into one of seven latches.
// R04: the target latch is chosen only by the three lowest shift register bits.
// R05: select codes 000 to 110 pick rf fb, rf ref, rf ctrl, global, if fb, if ref, if ctrl.
// R06: the global latch monitor select field steers the monitor output mux.
// R07: the monitor output can show either digital or analog lock indication.
// R08: digital lock drives the monitor output high when locked, low otherwise.
// R09: analog lock is open drain: released high when locked, brief low pulses.
// R10: rf integer divide value comes from bits 22 down to 15.
// R11: rf fractional numerator comes from bits 14 down to 3.
// R12: interpolator modulus comes from bits 14 down to 3 of the reference word.
// R13: reference word bit 20 picks prescaler ratio, bit 19 enables the doubler.
// R14: software keeps the rf integer value between 31 and 255.
// R15: software keeps modulus within 2 to 4095 and numerator not above it.
// R16: software keeps the rf reference ratio within 1 to 15.
// R17: select code 111 on a strobe edge changes no latch.
// R18: latches hold between strobe edges whatever the serial clock does.
`timescale 1ns/100ps
`default_nettype none

`include "synth_load_defines.svh"

module synth_serial_register_load (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial load pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_strobe,
    // lock status from the loops
    input wire logic rf_lock,
    input wire logic if_lock,
    input wire logic lock_pulse,
    // monitor output pin
    output logic monitor_output_pin_o,
    output logic monitor_output_pin_oe,
    // rf feedback divider
    output logic [7:0] rf_int,
    output logic [11:0] rf_frac,
    output logic [`RF_FB_W-1:0] rf_feedback_divider,
    // rf reference divider
    output logic [11:0] interpolator_modulus,
    output logic [3:0] rf_ref_ratio,
    output logic rf_prescaler_select,
    output logic rf_reference_doubler,
    output logic [`RF_REF_W-1:0] rf_reference_divider,
    // remaining latches
    output logic [`RF_CTRL_W-1:0] rf_loop_control,
    output logic [`GLOBAL_W-1:0] global_control,
    output logic [3:0] monitor_select,
    output logic [`IF_FB_W-1:0] if_feedback_divider,
    output logic [`IF_REF_W-1:0] if_reference_divider,
    output logic [`IF_CTRL_W-1:0] if_control
);

    synth_load_pkg::load_state_t st_q;
    synth_load_pkg::load_state_t st_d;
    logic [2:0] pins_sync;
    logic sclk_s;
    logic data_s;
    logic strobe_s;
    logic sclk_rise;
    logic strobe_rise;
    synth_load_pkg::latch_sel_t sel;
    synth_load_pkg::mon_sel_t mon_sel;

    // ===========================================================
    // pin synchronisers
    pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pins({latch_strobe, ser_data, ser_clk}),
        .pins_sync(pins_sync)
    );

    assign sclk_s = pins_sync[0];
    assign data_s = pins_sync[1];
    assign strobe_s = pins_sync[2];

    // edges seen against the previous synchronised level
    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction : rise

    assign sclk_rise = rise(sclk_s, st_q.sclk_prev); // [R01]
    assign strobe_rise = rise(strobe_s, st_q.strobe_prev); // [R03]

    // select code from the three lowest bits only
    assign sel = synth_load_pkg::latch_sel_t'(st_q.shift[`SEL_MSB:`SEL_LSB]); // [R04]
    assign mon_sel = synth_load_pkg::mon_sel_t'(st_q.glob[`MON_MSB:`MON_LSB]); // [R06]

    // ===========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.sclk_prev = sclk_s;
        st_d.strobe_prev = strobe_s;
        // a serial clock edge only moves the shift register, never a latch
        if (sclk_rise) begin
            st_d.shift = {st_q.shift[`SHIFT_W-2:0], data_s}; // [R01] [R02] [R18]
        end
        // load uses the word as it stood before any coincident shift
        if (strobe_rise) begin
            case (sel) // [R03] [R05]
                synth_load_pkg::sel_rf_feedback: begin
                    st_d.rf_fb = st_q.shift[`RF_FB_W-1:0];
                end
                synth_load_pkg::sel_rf_reference: begin
                    st_d.rf_ref = st_q.shift[`RF_REF_W-1:0];
                end
                synth_load_pkg::sel_rf_control: begin
                    st_d.rf_ctrl = st_q.shift[`RF_CTRL_W-1:0];
                end
                synth_load_pkg::sel_global: begin
                    st_d.glob = st_q.shift[`GLOBAL_W-1:0];
                end
                synth_load_pkg::sel_if_feedback: begin
                    st_d.if_fb = st_q.shift[`IF_FB_W-1:0];
                end
                synth_load_pkg::sel_if_reference: begin
                    st_d.if_ref = st_q.shift[`IF_REF_W-1:0];
                end
                synth_load_pkg::sel_if_control: begin
                    st_d.if_ctrl = st_q.shift[`IF_CTRL_W-1:0];
                end
                default: begin
                    // code 111: nothing is written
                    st_d.rf_fb = st_q.rf_fb; // [R17]
                end
            endcase
        end
        // monitor mux; unknown codes release the pin
        case (mon_sel) // [R06] [R07]
            synth_load_pkg::mon_digital_lock: begin
                st_d.mon_out = rf_lock & if_lock; // [R08]
                st_d.mon_oe = 1'b1;
            end
            synth_load_pkg::mon_analog_lock: begin
                // open drain: pull low unless locked and between pulses
                st_d.mon_out = 1'b0;
                st_d.mon_oe = ~(rf_lock & if_lock & ~lock_pulse); // [R09]
            end
            synth_load_pkg::mon_high: begin
                st_d.mon_out = 1'b1;
                st_d.mon_oe = 1'b1;
            end
            synth_load_pkg::mon_low: begin
                st_d.mon_out = 1'b0;
                st_d.mon_oe = 1'b1;
            end
            default: begin
                st_d.mon_out = 1'b0;
                st_d.mon_oe = 1'b0;
            end
        endcase
    end

    // ===========================================================
    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ===========================================================
    // outputs, all straight from the state register
    assign monitor_output_pin_o = st_q.mon_out;
    assign monitor_output_pin_oe = st_q.mon_oe;
    assign rf_feedback_divider = st_q.rf_fb;
    assign rf_int = st_q.rf_fb[`RF_INT_MSB:`RF_INT_LSB]; // [R10]
    assign rf_frac = st_q.rf_fb[`RF_FRAC_MSB:`RF_FRAC_LSB]; // [R11]
    assign rf_reference_divider = st_q.rf_ref;
    assign interpolator_modulus = st_q.rf_ref[`MOD_MSB:`MOD_LSB]; // [R12]
    assign rf_ref_ratio = st_q.rf_ref[`RF_R_MSB:`RF_R_LSB];
    assign rf_prescaler_select = st_q.rf_ref[`PRESC_BIT]; // [R13]
    assign rf_reference_doubler = st_q.rf_ref[`DOUBLER_BIT]; // [R13]
    assign rf_loop_control = st_q.rf_ctrl;
    assign global_control = st_q.glob;
    assign monitor_select = st_q.glob[`MON_MSB:`MON_LSB];
    assign if_feedback_divider = st_q.if_fb;
    assign if_reference_divider = st_q.if_ref;
    assign if_control = st_q.if_ctrl;

endmodule : synth_serial_register_load

`default_nettype wire

//--- sim/serial_host_model.sv
// host model driving the three serial load pins
// assumes: 24-bit words, pins asynchronous to the device clock
`timescale 1ns/100ps
`default_nettype none

module serial_host_model (
    // serial load pins
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // ===========================================================
    // word transfer: 40 ns halves give the device four samples per level
    task automatic send(input logic [23:0] w, input logic load);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #40 ser_clk = 1'b1;
            #40 ser_clk = 1'b0;
        end
        ser_data = ~w[0]; // no stale level after the frame
        #40 latch_strobe = load;
        #80 latch_strobe = 1'b0;
        #80;
    endtask : send
endmodule : serial_host_model

`default_nettype wire

//--- sim/synth_load_properties.sv
// assertions on the serial load port outputs
// assumes: bound to synth_serial_register_load, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "synth_load_defines.svh"

module synth_load_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // inputs
    input wire logic latch_strobe,
    input wire logic rf_lock,
    input wire logic if_lock,
    input wire logic lock_pulse,
    // outputs
    input wire logic monitor_output_pin_o,
    input wire logic monitor_output_pin_oe,
    input wire logic [7:0] rf_int,
    input wire logic [11:0] rf_frac,
    input wire logic [`RF_FB_W-1:0] rf_feedback_divider,
    input wire logic [11:0] interpolator_modulus,
    input wire logic rf_prescaler_select,
    input wire logic rf_reference_doubler,
    input wire logic [`RF_REF_W-1:0] rf_reference_divider,
    input wire logic [`GLOBAL_W-1:0] global_control,
    input wire logic [3:0] monitor_select,
    input wire logic [`IF_CTRL_W-1:0] if_control
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ===========================================================
    // fields and load timing
    int_field_a: assert property (rf_int == rf_feedback_divider[22:15])
        else $error("rf int field wrong");
    frac_field_a: assert property (rf_frac == rf_feedback_divider[14:3])
        else $error("rf frac field wrong");
    mod_field_a: assert property (interpolator_modulus == rf_reference_divider[14:3])
        else $error("modulus field wrong");
    ref_bits_a: assert property ({rf_prescaler_select, rf_reference_doubler}
        == rf_reference_divider[20:19]) else $error("prescaler or doubler bit wrong");
    latch_hold_a: assert property (!$stable({rf_feedback_divider, rf_reference_divider,
        global_control, if_control}) |-> $past(latch_strobe, 2)) else $error("load without strobe");
    select_code_a: assert property (($changed(rf_feedback_divider) |->
        rf_feedback_divider[2:0] == 3'h0) and ($changed(global_control) |->
        global_control[2:0] == 3'h3) and ($changed(if_control) |-> if_control[2:0] == 3'h6))
        else $error("wrong latch loaded");
    mon_select_a: assert property (monitor_select == global_control[10:7])
        else $error("monitor select field wrong");
    digital_lock_a: assert property (monitor_select == 4'h1 |=> monitor_output_pin_oe
        && monitor_output_pin_o == $past(rf_lock && if_lock)) else $error("digital lock wrong");
    analog_lock_a: assert property (monitor_select == 4'h2 |=> !monitor_output_pin_o
        && monitor_output_pin_oe == $past(!(rf_lock && if_lock && !lock_pulse)))
        else $error("analog lock wrong");
endmodule : synth_load_checker

bind synth_serial_register_load synth_load_checker u_chk (.clk_sys(clk_sys), .rst(rst),
    .latch_strobe(latch_strobe), .rf_lock(rf_lock), .if_lock(if_lock), .lock_pulse(lock_pulse),
    .monitor_output_pin_o(monitor_output_pin_o), .monitor_output_pin_oe(monitor_output_pin_oe),
    .rf_int(rf_int), .rf_frac(rf_frac), .rf_feedback_divider(rf_feedback_divider),
    .interpolator_modulus(interpolator_modulus), .rf_prescaler_select(rf_prescaler_select),
    .rf_reference_doubler(rf_reference_doubler), .rf_reference_divider(rf_reference_divider),
    .global_control(global_control), .monitor_select(monitor_select), .if_control(if_control));

`default_nettype wire

//--- sim/testbench.sv
// self-checking bench of the serial load port
// assumes: host model drives the pins; monitor pin pulled up
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic rf_lock = 1'b0;
    logic if_lock = 1'b0;
    logic lock_pulse = 1'b0;
    int failures = 0;
    int total_checks = 0;
    wire logic sclk, sdata, strobe, mo, moe, presc, dbl;
    wire logic [7:0] r_int;
    wire logic [11:0] r_frac, r_mod;
    wire logic [3:0] r_ratio, mon_sel;
    wire logic [23:0] rf_fb, if_fb;
    wire logic [20:0] rf_ref;
    wire logic [18:0] if_ref;
    wire logic [15:0] rf_ctl, if_ctl;
    wire logic [10:0] glob;
    wire logic [130:0] all_q = {rf_fb, rf_ref, rf_ctl, glob, if_fb, if_ref, if_ctl};
    wire logic pin = moe ? mo : 1'b1;

    serial_host_model u_host (.ser_clk(sclk), .ser_data(sdata), .latch_strobe(strobe));
    synth_serial_register_load u_dut (.clk_sys(clk_sys), .rst(rst), .ser_clk(sclk),
        .ser_data(sdata), .latch_strobe(strobe), .rf_lock(rf_lock), .if_lock(if_lock),
        .lock_pulse(lock_pulse), .monitor_output_pin_o(mo), .monitor_output_pin_oe(moe),
        .rf_int(r_int), .rf_frac(r_frac), .rf_feedback_divider(rf_fb),
        .interpolator_modulus(r_mod), .rf_ref_ratio(r_ratio), .rf_prescaler_select(presc),
        .rf_reference_doubler(dbl), .rf_reference_divider(rf_ref), .rf_loop_control(rf_ctl),
        .global_control(glob), .monitor_select(mon_sel), .if_feedback_divider(if_fb),
        .if_reference_divider(if_ref), .if_control(if_ctl));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ===========================================================
    // shared tasks
    task automatic check(input logic [130:0] seen, input logic [130:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // ===========================================================
    // scenarios
    task automatic t_rf(input logic [7:0] n, input logic [11:0] f, input logic [11:0] m,
        input logic [3:0] r, input logic p, input logic d);
        u_host.send({1'b0, n, f, 3'h0}, 1'b1);
        u_host.send({3'h0, p, d, r, m, 3'h1}, 1'b1);
        check(r_int, n);
        check(r_frac, f);
        check(r_mod, m);
        check({presc, dbl}, {p, d});
        check(r_ratio, r);
        $display("test rf fields done");
    endtask : t_rf

    task automatic t_codes;
        int wd[7] = '{24, 21, 16, 11, 24, 19, 16};
        logic [23:0] w;
        logic [130:0] got;
        for (int c = 0; c < 7; c++) begin
            w = {8'h5a + 8'(c), 13'h1ace, 3'(c)};
            u_host.send(w, 1'b1);
            case (c)
                0: got = rf_fb;
                1: got = rf_ref;
                2: got = rf_ctl;
                3: got = glob;
                4: got = if_fb;
                5: got = if_ref;
                default: got = if_ctl;
            endcase
            check(got, w & ~(24'hffffff << wd[c]));
        end
        $display("test select codes done");
    endtask : t_codes

    task automatic t_hold;
        logic [130:0] snap;
        snap = all_q;
        u_host.send(24'hffffff, 1'b1);
        check(all_q, snap);
        u_host.send(24'h123450, 1'b0);
        check(all_q, snap);
        $display("test hold done");
    endtask : t_hold

    task automatic t_monitor;
        logic [3:0] md[7] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h0};
        logic [6:0] lk = 7'b0101111;
        logic [6:0] il = 7'b1111101;
        logic [6:0] pl = 7'b0001000;
        logic [1:0] ex[7] = '{2'h3, 2'h2, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1};
        // step 1 has the rf loop locked but the if loop not: lock needs both
        for (int i = 0; i < 7; i++) begin
            u_host.send({13'h0, md[i], 7'h03}, 1'b1);
            @(negedge clk_sys);
            rf_lock = lk[i];
            if_lock = il[i];
            lock_pulse = pl[i];
            repeat (3) @(negedge clk_sys);
            check({moe, pin}, ex[i]);
            check(mon_sel, md[i]);
        end
        $display("test monitor done");
    endtask : t_monitor

    // ===========================================================
    // sequence and watchdog; whole run is about 43 us
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        #100;
        t_rf(8'hff, 12'h064, 12'hfff, 4'hf, 1'b1, 1'b0);
        t_rf(8'h1f, 12'h002, 12'h002, 4'h1, 1'b0, 1'b1);
        t_codes();
        t_hold();
        t_monitor();
        finish_test();
    end

    initial begin
        #300000;
        failures++;
        finish_test();
    end
endmodule : testbench

`default_nettype wire
